// ==== hdl/builtin_self_test.sv ====
// Self-test sequencer with programmable run length
`timescale 1ns/1ps
module builtin_self_test
   import reset_init_pkg::*;
#(
   parameter int unsigned TEST_CYCLES = TEST_PERIODS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic inject_fault,
   output logic busy,
   output logic done,
   output logic fail
);
   localparam int CNT_W = $clog2(TEST_CYCLES + 1);

   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic busy_ff, nxt_busy, done_ff, nxt_done, fail_ff, nxt_fail;
   logic [31:0] len_ff;

   // Countdown; a start while busy is ignored
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_fail = fail_ff;
      if (start && !busy_ff) begin
         nxt_busy = 1'b1;
         nxt_cnt = CNT_W'(TEST_CYCLES - 1);
         nxt_fail = inject_fault;
      end else if (busy_ff) begin
         if (cnt_ff == '0) begin
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
         end else begin
            nxt_cnt = cnt_ff - 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         fail_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         fail_ff <= nxt_fail;
      end
   end

   assign busy = busy_ff;
   assign done = done_ff;
   assign fail = fail_ff;

   // Helper: busy cycles of the current run, for the length check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_ff <= 32'h0000_0000;
      end else if (start && !busy_ff) begin
         len_ff <= 32'h0000_0000;
      end else if (busy_ff) begin
         len_ff <= len_ff + 32'h0000_0001;
      end
   end

   a_run_length: assert property (@(posedge pclk) disable iff (!presetn)
      done_ff |-> len_ff == TEST_CYCLES)
      else $error("self-test length differs from parameter");
   a_done_single: assert property (@(posedge pclk) disable iff (!presetn)
      done_ff |=> !done_ff && !busy_ff)
      else $error("done not a single-cycle pulse");

endmodule : builtin_self_test

// ==== hdl/mem_bank.sv ====
// Small register bank, lane-writable, registered read, cleared at reset
`timescale 1ns/1ps
module mem_bank #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8,
   parameter int LANES = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input wire logic [1:0] wr_lane,
   input wire logic [31:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [LANES*32-1:0] rd_data
);
   logic [LANES*32-1:0] arr_ff [DEPTH];
   logic [LANES*32-1:0] nxt_arr [DEPTH];
   logic [LANES*32-1:0] rd_ff;

   // Lane write; bits above WIDTH stay zero
   always_comb begin
      nxt_arr = arr_ff;
      if (wr_en && (int'(wr_lane) < LANES)) begin
         nxt_arr[wr_idx][wr_lane*32 +: 32] = wr_data;
      end
      for (int i = 0; i < DEPTH; i++) begin
         nxt_arr[i] = nxt_arr[i] & (LANES*32)'({WIDTH{1'b1}});
      end
   end

   // Async clear costs area but gives a zero bank before first fetch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            arr_ff[i] <= '0;
         end
         rd_ff <= '0;
      end else begin
         arr_ff <= nxt_arr;
         rd_ff <= arr_ff[rd_idx];
      end
   end

   assign rd_data = rd_ff;

endmodule : mem_bank

// ==== hdl/processor_reset_state_init.sv ====
// Reset-time architectural state with self-test, APB readback
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module processor_reset_state_init
   import reset_init_pkg::*;
#(
   parameter int unsigned TEST_CYCLES = TEST_PERIODS,
   parameter logic [31:0] ID_VALUE = ID_DEFAULT,
   parameter logic [31:0] FAIL_VALUE = FAIL_CODE
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic selftest_req_pin,
   input wire logic soft_init_n_pin,
   input wire logic fp_init_req,
   output logic fetch_enable,
   output logic tlb_invalidate,
   output logic btb_invalidate,
   output logic cache_invalidate
);
   phase_t phase_ff, nxt_phase;
   logic [1:0] wait_ff, nxt_wait;
   logic strap_meta_ff, strap_sync_ff, init_meta_ff, init_sync_ff;
   logic init_prev_ff;
   logic ran_ff, nxt_ran, fault_ff, nxt_fault;
   logic test_start, test_busy, test_done, test_fail;
   logic soft_init_evt, fp_init_evt;
   logic [31:0] gp_ff [GP_N];
   logic [31:0] nxt_gp [GP_N];
   logic [31:0] fpu_ff [FPU_N];
   logic [31:0] nxt_fpu [FPU_N];
   logic [15:0] sel_ff [SEG_N];
   logic [15:0] nxt_sel [SEG_N];
   logic [31:0] base_ff [SEG_N];
   logic [31:0] nxt_base [SEG_N];
   logic [DATA_W-1:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic fetch_ff, tlb_ff, btb_ff, cache_ff;
   logic [11:0] off_gp, off_seg, off_fpu, off_fps, off_pki;
   logic [31:0] rd_val;
   logic rd_ok, wr_ok, gp_hit, fpu_hit, fps_hit, pki_hit, ctrl_hit;
   logic xfer_ask, wr_commit;
   logic [FPS_LANES*32-1:0] fps_rd;
   logic [PKI_LANES*32-1:0] pki_rd;

   // Pin inputs: two flops each before any logic looks at them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_meta_ff <= 1'b0;
         strap_sync_ff <= 1'b0;
         init_meta_ff <= 1'b1;
         init_sync_ff <= 1'b1;
         init_prev_ff <= 1'b1;
      end else begin
         strap_meta_ff <= selftest_req_pin;
         strap_sync_ff <= strap_meta_ff;
         init_meta_ff <= soft_init_n_pin;
         init_sync_ff <= init_meta_ff;
         init_prev_ff <= init_sync_ff;
      end
   end

   // Soft init taken on the asserting edge, only once running
   assign soft_init_evt = !init_sync_ff && init_prev_ff &&
      (phase_ff == PH_RUN);
   assign fp_init_evt = fp_init_req ||
      (wr_commit && ctrl_hit && pwdata[CTRL_FPINIT_BIT]);

   // Start phase: strap is caught once the synchroniser has settled
   always_comb begin
      nxt_phase = phase_ff;
      nxt_wait = wait_ff;
      nxt_ran = ran_ff;
      test_start = 1'b0;
      unique case (phase_ff)
         PH_STRAP: begin
            if (wait_ff == STRAP_WAIT) begin
               if (strap_sync_ff) begin
                  test_start = 1'b1;
                  nxt_ran = 1'b1;
                  nxt_phase = PH_TEST;
               end else begin
                  nxt_phase = PH_RUN;
               end
            end else begin
               nxt_wait = wait_ff + 2'h1;
            end
         end
         PH_TEST: begin
            if (test_done) begin
               nxt_phase = PH_RUN;
            end
         end
         PH_RUN: begin
            nxt_phase = PH_RUN;
         end
         default: begin
            nxt_phase = PH_STRAP;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= PH_STRAP;
         wait_ff <= 2'h0;
         ran_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         wait_ff <= nxt_wait;
         ran_ff <= nxt_ran;
      end
   end

   builtin_self_test #(
      .TEST_CYCLES(TEST_CYCLES)
   ) u_test (
      .pclk(pclk),
      .presetn(presetn),
      .start(test_start),
      // Next fault value, so a write landing on the start edge still counts
      .inject_fault(nxt_fault),
      .busy(test_busy),
      .done(test_done),
      .fail(test_fail)
   );

   // Address decode and read mux; reads answer one wait state late
   always_comb begin
      off_gp = paddr - A_GP_BASE;
      off_seg = paddr - A_SEG_BASE;
      off_fpu = paddr - A_FPU_BASE;
      off_fps = paddr - A_FPS_BASE;
      off_pki = paddr - A_PKI_BASE;
      ctrl_hit = (paddr == A_CTRL);
      gp_hit = (off_gp < 12'(GP_N * 4)) && (paddr[1:0] == 2'h0);
      fpu_hit = (off_fpu < 12'(FPU_N * 4)) && (paddr[1:0] == 2'h0);
      fps_hit = (off_fps < 12'(FPS_N * 16)) && (paddr[1:0] == 2'h0) &&
         (int'(off_fps[3:2]) < FPS_LANES);
      pki_hit = (off_pki < 12'(PKI_N * 16)) && (paddr[1:0] == 2'h0) &&
         (int'(off_pki[3:2]) < PKI_LANES);
      rd_val = ZERO32;
      rd_ok = 1'b1;
      wr_ok = ctrl_hit || fpu_hit || fps_hit || pki_hit ||
         (gp_hit && (int'(off_gp[5:2]) != GP_ID));
      if (ctrl_hit) begin
         rd_val[CTRL_FAULT_BIT] = fault_ff;
      end else if (paddr == A_STATUS) begin
         rd_val[ST_FETCH_BIT] = fetch_ff;
         rd_val[ST_RAN_BIT] = ran_ff;
         rd_val[ST_BUSY_BIT] = test_busy;
         rd_val[ST_STRAP_BIT] = strap_sync_ff;
      end else if (gp_hit) begin
         rd_val = gp_ff[off_gp[5:2]];
      end else if ((off_seg < 12'(SEG_N * 16)) && (paddr[1:0] == 2'h0) &&
         (int'(off_seg[3:2]) < SEG_WORDS)) begin
         unique case (off_seg[3:2])
            2'h0: rd_val = {16'h0000, sel_ff[off_seg[6:4]]};
            2'h1: rd_val = base_ff[off_seg[6:4]];
            default: rd_val = {13'h0000, SEG_ATTR, SEG_LIMIT};
         endcase
      end else if (fpu_hit) begin
         rd_val = fpu_ff[off_fpu[4:2]];
      end else if (fps_hit) begin
         rd_val = fps_rd[off_fps[3:2]*32 +: 32];
      end else if (pki_hit) begin
         rd_val = pki_rd[off_pki[3:2]*32 +: 32];
      end else begin
         rd_ok = 1'b0;
      end
   end

   // APB slave: pready raised in the second access cycle
   assign xfer_ask = psel && penable && !pready_ff;
   assign wr_commit = psel && penable && pready_ff && pwrite && wr_ok;

   always_comb begin
      nxt_pready = xfer_ask;
      nxt_pslverr = xfer_ask && (pwrite ? !wr_ok : !rd_ok);
      nxt_prdata = (xfer_ask && !pwrite) ? rd_val : ZERO32;
      nxt_fault = (wr_commit && ctrl_hit) ? pwdata[CTRL_FAULT_BIT] :
         fault_ff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= ZERO32;
         fault_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff <= nxt_prdata;
         fault_ff <= nxt_fault;
      end
   end

   // General regs: soft init reload, then test result, then software
   always_comb begin
      nxt_gp = gp_ff;
      if (wr_commit && gp_hit) begin
         nxt_gp[off_gp[5:2]] = pwdata;
      end
      if (test_done) begin
         nxt_gp[GP_ACC] = test_fail ? FAIL_VALUE : ZERO32;
      end
      if (soft_init_evt) begin
         nxt_gp = GP_RST;
         nxt_gp[GP_ID] = ID_VALUE;
         nxt_gp[GP_CR0] = (gp_ff[GP_CR0] & CR0_KEEP_MASK) | CR0_INIT_SET;
      end
   end

   // Segment state reloads on soft init as well
   always_comb begin
      nxt_sel = sel_ff;
      nxt_base = base_ff;
      if (soft_init_evt) begin
         for (int i = 0; i < SEG_N; i++) begin
            nxt_sel[i] = (i == 0) ? CS_SEL : DSEG_SEL;
            nxt_base[i] = (i == 0) ? CS_BASE : DSEG_BASE;
         end
      end
   end

   // Fp environment: soft init leaves it, fp init wins over software
   always_comb begin
      nxt_fpu = fpu_ff;
      if (wr_commit && fpu_hit) begin
         nxt_fpu[off_fpu[4:2]] = pwdata;
      end
      if (fp_init_evt) begin
         nxt_fpu = FPU_FINIT;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gp_ff <= GP_RST;
         gp_ff[GP_ID] <= ID_VALUE;
         fpu_ff <= FPU_RST;
         for (int i = 0; i < SEG_N; i++) begin
            sel_ff[i] <= (i == 0) ? CS_SEL : DSEG_SEL;
            base_ff[i] <= (i == 0) ? CS_BASE : DSEG_BASE;
         end
      end else begin
         gp_ff <= nxt_gp;
         fpu_ff <= nxt_fpu;
         sel_ff <= nxt_sel;
         base_ff <= nxt_base;
      end
   end

   // Banks see only bus writes, so both init kinds leave them intact
   mem_bank #(
      .WIDTH(FPS_W),
      .DEPTH(FPS_N),
      .LANES(FPS_LANES)
   ) u_fp_stack (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_commit && fps_hit),
      .wr_idx(off_fps[6:4]),
      .wr_lane(off_fps[3:2]),
      .wr_data(pwdata),
      .rd_idx(paddr[6:4]),
      .rd_data(fps_rd)
   );

   mem_bank #(
      .WIDTH(PKI_W),
      .DEPTH(PKI_N),
      .LANES(PKI_LANES)
   ) u_packed (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_commit && pki_hit),
      .wr_idx(off_pki[6:4]),
      .wr_lane(off_pki[3:2]),
      .wr_data(pwdata),
      .rd_idx(paddr[6:4]),
      .rd_data(pki_rd)
   );

   // Core-facing strobes; cache flush only on hard reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_ff <= 1'b0;
         tlb_ff <= 1'b0;
         btb_ff <= 1'b0;
         cache_ff <= 1'b0;
      end else begin
         fetch_ff <= (nxt_phase == PH_RUN);
         tlb_ff <= soft_init_evt || (phase_ff == PH_STRAP && wait_ff ==
            2'h0);
         btb_ff <= soft_init_evt || (phase_ff == PH_STRAP && wait_ff ==
            2'h0);
         cache_ff <= (phase_ff == PH_STRAP && wait_ff == 2'h0);
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign fetch_enable = fetch_ff;
   assign tlb_invalidate = tlb_ff;
   assign btb_invalidate = btb_ff;
   assign cache_invalidate = cache_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fetch_after_test: assert property (
      fetch_ff |-> !test_busy && !test_start)
      else $error("fetch enabled while self-test pending");
   a_acc_pass_zero: assert property (
      test_done && !test_fail |=> gp_ff[GP_ACC] == ZERO32)
      else $error("accumulator not zero after passing test");
   a_acc_fail_set: assert property (
      test_done && test_fail |=> gp_ff[GP_ACC] != ZERO32)
      else $error("accumulator zero after failing test");
   a_no_req_acc: assert property (
      $rose(fetch_ff) && !ran_ff |-> gp_ff[GP_ACC] == ZERO32)
      else $error("accumulator nonzero without self-test");
   a_start_needs_strap: assert property (
      test_start |-> strap_sync_ff && phase_ff == PH_STRAP)
      else $error("self-test started without request");
   a_init_no_test: assert property (
      soft_init_evt |=> !test_busy ##1 !test_busy)
      else $error("soft init started the self-test");
   a_init_reload: assert property (
      soft_init_evt |=> gp_ff[GP_IP] == IP_RST &&
      gp_ff[GP_FLAGS] == FLAGS_RST)
      else $error("soft init did not reload pointer and flags");
   a_init_cr0_keep: assert property (
      soft_init_evt |=> gp_ff[GP_CR0] == (($past(gp_ff[GP_CR0]) &
      CR0_KEEP_MASK) | CR0_INIT_SET))
      else $error("soft init control reg value wrong");
   a_init_keeps_fp: assert property (
      soft_init_evt && !fp_init_evt && !wr_commit |=>
      $stable(fpu_ff[FPU_CTRL]) && $stable(fpu_ff[FPU_TAG]))
      else $error("soft init disturbed fp state");
   a_fpinit_words: assert property (
      fp_init_evt |=> fpu_ff[FPU_CTRL] == 32'h0000_037F &&
      fpu_ff[FPU_TAG] == 32'h0000_FFFF)
      else $error("fp init values wrong");
   a_ready_pulse: assert property (
      xfer_ask |=> pready_ff ##1 !pready_ff)
      else $error("pready not a one-cycle answer");

   c_test_pass: cover property (test_done && !test_fail);
   c_test_fail: cover property (test_done && test_fail);
   c_soft_init: cover property (soft_init_evt);
   c_fp_init: cover property (fp_init_evt ##1 fetch_ff);

endmodule : processor_reset_state_init

// ==== hdl/reset_init_pkg.sv ====
// Shared constants, reset values and types for the reset-state block
package reset_init_pkg;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register map, byte addresses
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STATUS = 12'h004;
   localparam logic [11:0] A_GP_BASE = 12'h010;
   localparam logic [11:0] A_SEG_BASE = 12'h080;
   localparam logic [11:0] A_FPU_BASE = 12'h100;
   localparam logic [11:0] A_FPS_BASE = 12'h200;
   localparam logic [11:0] A_PKI_BASE = 12'h300;

   // Control and status bit positions
   localparam int CTRL_FAULT_BIT = 0;
   localparam int CTRL_FPINIT_BIT = 1;
   localparam int ST_FETCH_BIT = 0;
   localparam int ST_RAN_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_STRAP_BIT = 3;

   // General register file, word index order
   localparam int GP_N = 14;
   localparam int GP_FLAGS = 0;
   localparam int GP_IP = 1;
   localparam int GP_CR0 = 2;
   localparam int GP_ACC = 6;
   localparam int GP_ID = 7;

   // Reset values of the general register file
   localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
   localparam logic [31:0] IP_RST = 32'h0000_FFF0;
   localparam logic [31:0] CR0_RST = 32'h6000_0010;
   localparam logic [31:0] CR0_KEEP_MASK = 32'h6000_0000;
   localparam logic [31:0] CR0_INIT_SET = 32'h0000_0010;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [31:0] GP_RST [GP_N] = '{FLAGS_RST, IP_RST, CR0_RST,
      ZERO32, ZERO32, ZERO32, ZERO32, ZERO32, ZERO32, ZERO32, ZERO32,
      ZERO32, ZERO32, ZERO32};
   // Identification value; arbitrary neutral value
   localparam logic [31:0] ID_DEFAULT = 32'h0000_0A5A;
   // Nonzero accumulator value for a failed self-test
   localparam logic [31:0] FAIL_CODE = 32'h0000_0001;

   // Segments: index 0 is the code segment, 1..5 stack and data
   localparam int SEG_N = 6;
   localparam int SEG_WORDS = 3;
   localparam logic [15:0] CS_SEL = 16'hF000;
   localparam logic [31:0] CS_BASE = 32'hFFFF_0000;
   localparam logic [15:0] DSEG_SEL = 16'h0000;
   localparam logic [31:0] DSEG_BASE = 32'h0000_0000;
   localparam logic [15:0] SEG_LIMIT = 16'hFFFF;
   // Attributes: present, read/write, accessed
   localparam logic [2:0] SEG_ATTR = 3'h7;

   // Floating-point environment words
   localparam int FPU_N = 7;
   localparam int FPU_CTRL = 0;
   localparam int FPU_TAG = 2;
   localparam logic [31:0] FPU_RST [FPU_N] = '{32'h0000_0040, ZERO32,
      32'h0000_5555, ZERO32, ZERO32, ZERO32, ZERO32};
   localparam logic [31:0] FPU_FINIT [FPU_N] = '{32'h0000_037F, ZERO32,
      32'h0000_FFFF, ZERO32, ZERO32, ZERO32, ZERO32};

   // Register banks: stack regs hold +0.0 at reset, packed regs zero
   localparam int FPS_N = 8;
   localparam int FPS_W = 80;
   localparam int FPS_LANES = 3;
   localparam int PKI_N = 8;
   localparam int PKI_W = 64;
   localparam int PKI_LANES = 2;

   // Self-test length in core clock periods
   localparam int unsigned TEST_PERIODS = 5_500_000;
   // Edges to wait after release so the strap synchroniser has settled
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   typedef enum logic [2:0] {
      PH_STRAP = 3'b001,
      PH_TEST = 3'b010,
      PH_RUN = 3'b100
   } phase_t;

endpackage : reset_init_pkg

// ==== tb/reset_logic_model.sv ====
// System reset logic model: self-test strap and soft init pin
`timescale 1ns/1ps
module reset_logic_model (
   input wire logic pclk,
   input wire logic strap_on,
   input wire logic init_go,
   output logic selftest_req_pin,
   output logic soft_init_n_pin
);
   logic [2:0] low_cnt_ff = 3'h0;
   // Strap set with reset and held, so it is steady from release
   assign selftest_req_pin = strap_on;
   // Soft init held low four cycles, high again before the next one
   always_ff @(posedge pclk) begin
      if (init_go) begin
         low_cnt_ff <= 3'h4;
      end else if (low_cnt_ff != 3'h0) begin
         low_cnt_ff <= low_cnt_ff - 3'h1;
      end
   end
   assign soft_init_n_pin = (low_cnt_ff == 3'h0);
endmodule : reset_logic_model

// ==== tb/testbench.sv ====
// Self-checking bench for the reset-state block
`timescale 1ns/1ps
module testbench;
   import reset_init_pkg::*;
   localparam logic [31:0] CR0I = 32'h6000_0010;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic strap_on = 1'b0;
   logic init_go = 1'b0;
   logic fp_init_req = 1'b0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, fetch_enable, selftest_req_pin;
   logic tlb_invalidate, btb_invalidate, cache_invalidate, soft_init_n_pin;
   logic [31:0] fps_exp [24];
   logic [31:0] pki_exp [16];
   int n_fail = 0;
   int check_count = 0;
   int n_tlb = 0;
   int n_cache = 0;
   int t, c;

   processor_reset_state_init #(.TEST_CYCLES(20))
      processor_reset_state_init_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .selftest_req_pin, .soft_init_n_pin, .fp_init_req, .fetch_enable,
      .tlb_invalidate, .btb_invalidate, .cache_invalidate);
   reset_logic_model reset_logic_model_inst (.pclk, .strap_on, .init_go,
      .selftest_req_pin, .soft_init_n_pin);

   initial begin
      forever #2.5 pclk = ~pclk;
   end

   // Pulses counted mid-cycle, away from the launching edge
   always @(negedge pclk) begin
      if (tlb_invalidate === 1'b1 && btb_invalidate === 1'b1) n_tlb++;
      if (cache_invalidate === 1'b1) n_cache++;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic cmp(input logic [31:0] got, input logic [31:0] e);
      check_count++;
      if (got !== e) begin
         n_fail++;
         $display("wrong value at %0t got %h expected %h", $time, got, e);
      end
   endtask : cmp

   // One APB transfer; entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int i = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready and data are taken at the rising edge that samples them
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_fail++;
         print_verdict();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input logic er);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rdat, e);
      cmp({31'h0, rerr}, {31'h0, er});
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic er);
      apb(1'b1, a, d);
      cmp({31'h0, rerr}, {31'h0, er});
   endtask : wr

   function automatic logic [31:0] exp_gp(input int k, input logic [31:0] cr);
      case (k)
         0: return 32'h0000_0002;
         1: return 32'h0000_FFF0;
         2: return cr;
         7: return ID_DEFAULT;
         default: return 32'h0000_0000;
      endcase
   endfunction : exp_gp

   function automatic logic [31:0] exp_seg(input int k);
      if (k % 3 == 2) return 32'h0007_FFFF;
      if (k == 0) return 32'h0000_F000;
      if (k == 1) return 32'hFFFF_0000;
      return 32'h0000_0000;
   endfunction : exp_seg

   function automatic logic [31:0] exp_fpu(input int k, input logic fi);
      if (k == 0) return fi ? 32'h0000_037F : 32'h0000_0040;
      if (k == 2) return fi ? 32'h0000_FFFF : 32'h0000_5555;
      return 32'h0000_0000;
   endfunction : exp_fpu

   // All visible state except the control register against the expected image
   task automatic chk(input logic s, input logic fi, input logic [31:0] cr);
      int k;
      for (k = 0; k < GP_N; k++) begin
         rd(A_GP_BASE + 12'(4 * k), exp_gp(k, cr), 1'b0);
      end
      for (k = 0; k < 18; k++) begin
         rd(A_SEG_BASE + 12'(16 * (k / 3) + 4 * (k % 3)), exp_seg(k), 1'b0);
      end
      for (k = 0; k < FPU_N; k++) begin
         rd(A_FPU_BASE + 12'(4 * k), exp_fpu(k, fi), 1'b0);
      end
      for (k = 0; k < 24; k++) begin
         rd(A_FPS_BASE + 12'(16 * (k / 3) + 4 * (k % 3)), fps_exp[k], 1'b0);
      end
      for (k = 0; k < 16; k++) begin
         rd(A_PKI_BASE + 12'(16 * (k / 2) + 4 * (k % 2)), pki_exp[k], 1'b0);
      end
      rd(A_STATUS, {28'h0, s, 1'b0, s, 1'b1}, 1'b0);
   endtask : chk

   // Random words into both banks; top stack lane keeps 16 bits
   task automatic fill;
      int k;
      logic [31:0] d;
      for (k = 0; k < 24; k++) begin
         d = $urandom;
         wr(A_FPS_BASE + 12'(16 * (k / 3) + 4 * (k % 3)), d, 1'b0);
         fps_exp[k] = (k % 3 == 2) ? {16'h0, d[15:0]} : d;
      end
      for (k = 0; k < 16; k++) begin
         d = $urandom;
         wr(A_PKI_BASE + 12'(16 * (k / 2) + 4 * (k % 2)), d, 1'b0);
         pki_exp[k] = d;
      end
   endtask : fill

   // Fault write rides along the release and lands on the strap decision edge
   task automatic do_reset(input logic s, input logic f);
      int i = 0;
      foreach (fps_exp[k]) fps_exp[k] = 32'h0000_0000;
      foreach (pki_exp[k]) pki_exp[k] = 32'h0000_0000;
      presetn <= 1'b0;
      strap_on <= s;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      if (f) apb(1'b1, A_CTRL, 32'h0000_0001);
      @(negedge pclk);
      cmp({31'h0, fetch_enable}, 32'h0);
      while (fetch_enable !== 1'b1 && i < 200) begin
         @(negedge pclk);
         i++;
      end
      if (i >= 200) begin
         n_fail++;
         print_verdict();
      end
      @(posedge pclk);
   endtask : do_reset

   initial begin
      repeat (100000) @(posedge pclk);
      n_fail++;
      print_verdict();
   end

   initial begin
      void'($urandom(19167));
      do_reset(1'b0, 1'b0);
      chk(1'b0, 1'b0, CR0I);
      wr(12'h02C, 32'h0000_1111, 1'b1);
      rd(12'h02C, ID_DEFAULT, 1'b0);
      wr(A_STATUS, 32'h0000_000F, 1'b1);
      rd(12'hFFC, 32'h0000_0000, 1'b1);
      $display("test reset values done");
      fill();
      wr(A_FPU_BASE, 32'h0000_0123, 1'b0);
      fp_init_req <= 1'b1;
      @(posedge pclk);
      fp_init_req <= 1'b0;
      @(posedge pclk);
      chk(1'b0, 1'b1, CR0I);
      wr(A_FPU_BASE + 12'h008, 32'h0000_0000, 1'b0);
      wr(A_CTRL, 32'h0000_0002, 1'b0);
      chk(1'b0, 1'b1, CR0I);
      $display("test fp init done");
      wr(A_GP_BASE + 12'h008, 32'h0000_0000, 1'b0);
      wr(A_GP_BASE + 12'h020, $urandom, 1'b0);
      wr(A_GP_BASE + 12'h018, $urandom, 1'b0);
      t = n_tlb;
      c = n_cache;
      init_go <= 1'b1;
      @(posedge pclk);
      init_go <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(1'b0, 1'b1, 32'h0000_0010);
      cmp(32'(n_tlb - t), 32'h1);
      cmp(32'(n_cache - c), 32'h0);
      $display("test soft init done");
      do_reset(1'b1, 1'b0);
      chk(1'b1, 1'b0, CR0I);
      do_reset(1'b1, 1'b1);
      rd(A_GP_BASE + 12'h018, FAIL_CODE, 1'b0);
      $display("test self-test done");
      print_verdict();
   end
endmodule : testbench
